// ==== mcba_pkg.sv ====
package mcba_pkg;

  // datapath and microword shape
  localparam int MCBA_DW = 8;
  localparam int MCBA_SLICE_W = 4;
  localparam int MCBA_NSLICE = 2;
  localparam int MCBA_MW_W = 35;
  localparam int MCBA_NREG = 16;

  // microword field positions
  localparam int MCBA_DST_HI = 34;
  localparam int MCBA_DST_LO = 32;
  localparam int MCBA_DIR_BIT = 33;
  localparam int MCBA_FN_HI = 31;
  localparam int MCBA_FN_LO = 29;
  localparam int MCBA_SRC_HI = 28;
  localparam int MCBA_SRC_LO = 26;
  localparam int MCBA_DER_RD_BIT = 23;
  localparam int MCBA_BADR_HI = 15;
  localparam int MCBA_BADR_LO = 12;
  localparam int MCBA_AADR_HI = 11;
  localparam int MCBA_AADR_LO = 8;
  localparam int MCBA_LS_BIT = 7;
  localparam int MCBA_DER_BIT = 5;
  localparam int MCBA_CC_BIT = 3;
  localparam int MCBA_END_HI = 1;
  localparam int MCBA_END_LO = 0;

  // timing: four phases of the 10 MHz base period
  localparam int MCBA_SYS_HZ = 25_000_000;
  localparam int MCBA_BASE_HZ = 10_000_000;
  localparam int MCBA_PHASE_NS = 100;
  localparam int MCBA_SYS_NS = 1_000_000_000 / MCBA_SYS_HZ;
  localparam int MCBA_PHASE_CYC = (MCBA_PHASE_NS + MCBA_SYS_NS - 1) / MCBA_SYS_NS;
  localparam int MCBA_NPHASE = 4;

  // axi4-lite register offsets
  localparam logic [4:0] MCBA_CTRL_OFS = 5'h00;
  localparam logic [4:0] MCBA_MWLO_OFS = 5'h04;
  localparam logic [4:0] MCBA_MWHI_OFS = 5'h08;
  localparam logic [4:0] MCBA_STAT_OFS = 5'h0C;
  localparam logic [4:0] MCBA_AB_OFS = 5'h10;
  // control bits
  localparam int MCBA_CTRL_RUN = 0;
  localparam int MCBA_CTRL_CIN = 1;
  localparam int MCBA_CTRL_STEP = 2;
  // reset values and response codes
  localparam logic [1:0] MCBA_CTRL_RST = 2'h0;
  localparam logic [MCBA_MW_W-1:0] MCBA_MW_RST = 35'h0;
  localparam logic [1:0] MCBA_RESP_OK = 2'h0;
  localparam logic [1:0] MCBA_RESP_ERR = 2'h2;

  // function codes
  typedef enum logic [2:0] {
    MCBA_FN_ADD = 3'h0, MCBA_FN_SUBR = 3'h1, MCBA_FN_SUBS = 3'h2, MCBA_FN_OR = 3'h3,
    MCBA_FN_AND = 3'h4, MCBA_FN_NOTRS = 3'h5, MCBA_FN_XOR = 3'h6, MCBA_FN_XNOR = 3'h7
  } mcba_fn_t;

  // destination codes
  typedef enum logic [2:0] {
    MCBA_DS_QREG = 3'h0, MCBA_DS_NOP = 3'h1, MCBA_DS_RAMA = 3'h2, MCBA_DS_RAMF = 3'h3,
    MCBA_DS_RAMQD = 3'h4, MCBA_DS_RAMD = 3'h5, MCBA_DS_RAMQU = 3'h6, MCBA_DS_RAMU = 3'h7
  } mcba_dst_t;

  // captured condition codes
  typedef struct packed {
    logic zero;
    logic overflow;
    logic sign;
    logic carry;
  } mcba_flags_t;

endpackage : mcba_pkg

// ==== mcba_phase.sv ====
module mcba_phase
  import mcba_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic go_in,
  // phase outputs
  output logic busy_out,
  output logic early_phase_window_out,
  output logic late_phase_strobe_out,
  output logic cycle_end_out
);

  logic [7:0] cyc_reg; // system clocks within a phase
  logic [1:0] phase_reg; // T0, T100, T200, T300
  logic last_cyc;

  assign last_cyc = (cyc_reg == 8'(MCBA_PHASE_CYC - 1));
  // busy once a microcycle has begun; idle only at the T0 boundary
  assign busy_out = go_in || (cyc_reg != 8'h00) || (phase_reg != 2'h0);
  assign early_phase_window_out = (phase_reg == 2'h0);
  assign late_phase_strobe_out = (phase_reg == 2'(MCBA_NPHASE - 1));
  assign cycle_end_out = busy_out && late_phase_strobe_out && last_cyc;

  // phase counter: a started microcycle always runs to its end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_reg <= 8'h00;
      phase_reg <= 2'h0;
    end else if (busy_out) begin
      if (last_cyc) begin
        cyc_reg <= 8'h00;
        phase_reg <= phase_reg + 2'h1;
      end else begin
        cyc_reg <= cyc_reg + 8'h01;
      end
    end
  end

endmodule : mcba_phase

// ==== mcba_slice.sv ====
module mcba_slice
  import mcba_pkg::*;
(
  // operands
  input wire logic [MCBA_SLICE_W-1:0] r_in,
  input wire logic [MCBA_SLICE_W-1:0] s_in,
  input wire logic cin_in,
  input wire logic [2:0] fn_in,
  // result
  output logic [MCBA_SLICE_W-1:0] f_out,
  output logic cmsb_out,
  output logic cout_out
);

  logic [MCBA_SLICE_W:0] sum;
  logic [MCBA_SLICE_W-1:0] sum_lo;
  logic [MCBA_SLICE_W-1:0] x;
  logic [MCBA_SLICE_W-1:0] y;

  // arithmetic is x + y + c; subtraction folds into the adder by inversion
  always_comb begin
    x = r_in;
    y = s_in;
    unique case (mcba_fn_t'(fn_in))
      MCBA_FN_SUBR: x = ~r_in;
      MCBA_FN_SUBS: y = ~s_in;
      default: x = r_in;
    endcase
  end

  assign sum = {1'b0, x} + {1'b0, y} + {4'h0, cin_in};
  // carry into the top bit, for overflow of the upper slice
  assign sum_lo = {1'b0, x[2:0]} + {1'b0, y[2:0]} + {3'h0, cin_in};
  assign cmsb_out = (fn_in <= 3'h2) ? sum_lo[3] : 1'b0;

  // function select; logic functions leave carry low
  always_comb begin
    f_out = sum[3:0];
    cout_out = 1'b0;
    unique case (mcba_fn_t'(fn_in))
      MCBA_FN_ADD, MCBA_FN_SUBR, MCBA_FN_SUBS: begin
        f_out = sum[3:0];
        cout_out = sum[4];
      end
      MCBA_FN_OR: f_out = r_in | s_in;
      MCBA_FN_AND: f_out = r_in & s_in;
      MCBA_FN_NOTRS: f_out = ~r_in & s_in;
      MCBA_FN_XOR: f_out = r_in ^ s_in;
      MCBA_FN_XNOR: f_out = ~(r_in ^ s_in);
    endcase
  end

endmodule : mcba_slice

// ==== mcba_top.sv ====
// Functional notes
// - eight bits from two cascaded nibble slices
// - bits 31:29 pick one of eight functions
// - bits 28:26 pick R and S operands
// - sixteen registers, A and B read ports
// - latches transparent outside late strobe, else hold
// - file writes B register during late strobe
// - Q loads at late strobe release
// - destination code sets stores and bus source
// - bit 33 direction, bits 1:0 end mode
// - downward shift top fills per end mode
// - upward shift bottom fills per end mode
// - Q end line direction, floats without shift
// - bus driver off on register or store reads
// - bus driver off during first quarter
// - flags captured at cycle end when bit 3
// - zero, overflow, sign, carry flag definitions
// - four phases of 10 MHz base period
module mcba_top
  import mcba_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // axi4-lite write address and data
  input wire logic [4:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // axi4-lite read
  input wire logic [4:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // internal byte bus
  input wire logic [MCBA_DW-1:0] BUS_IN,
  output logic [MCBA_DW-1:0] BUS_OUT,
  output logic BUS_OE_N_OUT,
  // q shifter end lines
  output logic ACCUM_SHIFT_TOP_LINE_OUT,
  output logic ACCUM_SHIFT_TOP_LINE_OE_N_OUT,
  output logic ACCUM_SHIFT_BOTTOM_LINE_OUT,
  output logic ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT,
  // condition codes and phases
  output mcba_flags_t FLAGS_OUT,
  output logic EARLY_PHASE_WINDOW_OUT,
  output logic LATE_PHASE_STROBE_OUT
);

  // software control state
  logic run_reg; // free-running microcycles
  logic cin_reg; // carry-in to the lower slice
  logic step_reg; // one microcycle pending
  logic [MCBA_MW_W-1:0] mw_next_reg; // next microword as written
  logic [MCBA_MW_W-1:0] microword_register; // microword under execution

  // datapath state
  logic [MCBA_DW-1:0] work_file [MCBA_NREG]; // sixteen work registers
  logic [MCBA_DW-1:0] a_lat_reg; // A latch
  logic [MCBA_DW-1:0] b_lat_reg; // B latch
  logic [MCBA_DW-1:0] q_reg; // Q register
  logic [MCBA_DW-1:0] f_hold_reg; // last result, for readback
  mcba_flags_t cc_reg; // condition code register
  logic [MCBA_DW-1:0] bus_s1_reg; // bus synchroniser, first stage
  logic [MCBA_DW-1:0] bus_s2_reg; // bus synchroniser, second stage

  // phase timing
  logic busy, early_phase_window, late_phase_strobe, cycle_end;

  // decoded microword
  logic [2:0] fn;
  logic [2:0] src;
  mcba_dst_t dst;
  logic [3:0] a_addr;
  logic [3:0] b_addr;
  logic shift_up;
  logic [1:0] end_mode;

  // operand and result nets
  logic [MCBA_DW-1:0] a_data, b_data, r_op, s_op, f, ram_in, q_in;
  logic [MCBA_NSLICE:0] carry; // carry chain between slices
  logic [MCBA_NSLICE-1:0] cmsb; // carry into each slice's top bit
  logic ram_top_fill, ram_bot_fill, q_top_fill, q_bot_fill; // shifter end fills
  logic file_wr, q_ld;
  mcba_flags_t flags_now;
  logic bus_drive;

  // axi state
  logic aw_held_reg;
  logic [4:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write, wr_hit, step_set;

  // phase generator
  mcba_phase u_phase (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .go_in(run_reg || step_reg),
    .busy_out(busy),
    .early_phase_window_out(early_phase_window),
    .late_phase_strobe_out(late_phase_strobe),
    .cycle_end_out(cycle_end)
  );

  // field decode from the executing microword
  assign fn = microword_register[MCBA_FN_HI:MCBA_FN_LO];
  assign src = microword_register[MCBA_SRC_HI:MCBA_SRC_LO];
  assign dst = mcba_dst_t'(microword_register[MCBA_DST_HI:MCBA_DST_LO]);
  assign a_addr = microword_register[MCBA_AADR_HI:MCBA_AADR_LO];
  assign b_addr = microword_register[MCBA_BADR_HI:MCBA_BADR_LO];
  assign shift_up = microword_register[MCBA_DIR_BIT];
  assign end_mode = microword_register[MCBA_END_HI:MCBA_END_LO];

  // both ports read the file independently; equal addresses see one register
  assign a_data = work_file[a_addr];
  assign b_data = work_file[b_addr];

  // bus synchroniser: the pin is asynchronous to the system clock
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_s1_reg <= 8'h00;
      bus_s2_reg <= 8'h00;
    end else begin
      bus_s1_reg <= BUS_IN;
      bus_s2_reg <= bus_s1_reg;
    end
  end

  // A/B latches follow the file outside the late strobe, hold inside it
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      a_lat_reg <= 8'h00;
      b_lat_reg <= 8'h00;
    end else if (!late_phase_strobe) begin
      a_lat_reg <= a_data;
      b_lat_reg <= b_data;
    end
  end

  // operand muxes; a zero operand is the inhibited mux
  always_comb begin
    r_op = 8'h00;
    s_op = 8'h00;
    unique case (src)
      3'h0: r_op = a_lat_reg;
      3'h1: begin
        r_op = a_lat_reg;
        s_op = b_lat_reg;
      end
      3'h2: s_op = q_reg;
      3'h3: s_op = b_lat_reg;
      3'h4: s_op = a_lat_reg;
      3'h5: begin
        r_op = bus_s2_reg;
        s_op = a_lat_reg;
      end
      3'h6: begin
        r_op = bus_s2_reg;
        s_op = q_reg;
      end
      3'h7: r_op = bus_s2_reg;
    endcase
  end

  // two nibble slices with carry passed from lower to upper
  assign carry[0] = (fn == 3'h1 || fn == 3'h2) ? ~cin_reg : cin_reg;
  genvar gi;
  generate
    for (gi = 0; gi < MCBA_NSLICE; gi++) begin : g_slice
      mcba_slice u_slice (
        .r_in(r_op[gi*MCBA_SLICE_W +: MCBA_SLICE_W]),
        .s_in(s_op[gi*MCBA_SLICE_W +: MCBA_SLICE_W]),
        .cin_in(carry[gi]),
        .fn_in(fn),
        .f_out(f[gi*MCBA_SLICE_W +: MCBA_SLICE_W]),
        .cmsb_out(cmsb[gi]),
        .cout_out(carry[gi+1])
      );
    end
  endgenerate

  // flags of the current result
  assign flags_now.zero = (f == 8'h00);
  assign flags_now.overflow = cmsb[MCBA_NSLICE-1] ^ carry[MCBA_NSLICE];
  assign flags_now.sign = f[MCBA_DW-1];
  assign flags_now.carry = carry[MCBA_NSLICE];

  // end fills; mode 0 fills zero, modes 2 and 3 feed the bits leaving F and Q back in, mode 1 only one of them
  always_comb begin
    ram_top_fill = 1'b0;
    ram_bot_fill = 1'b0;
    q_top_fill = 1'b0;
    q_bot_fill = 1'b0;
    if (!shift_up) begin
      unique case (end_mode)
        2'h0: q_top_fill = 1'b0;
        2'h1: q_top_fill = f[0];
        2'h2: begin
          ram_top_fill = f[0];
          q_top_fill = q_reg[0];
        end
        2'h3: begin
          ram_top_fill = q_reg[0];
          q_top_fill = f[0];
        end
      endcase
    end else begin
      unique case (end_mode)
        2'h0: q_bot_fill = 1'b0;
        2'h1: ram_bot_fill = q_reg[7];
        2'h2: begin
          ram_bot_fill = f[7];
          q_bot_fill = q_reg[7];
        end
        2'h3: begin
          ram_bot_fill = q_reg[7];
          q_bot_fill = f[7];
        end
      endcase
    end
  end

  // destination decode: what the file and Q receive
  always_comb begin
    ram_in = f;
    q_in = f;
    file_wr = 1'b1;
    q_ld = 1'b0;
    unique case (dst)
      MCBA_DS_QREG: begin
        file_wr = 1'b0;
        q_ld = 1'b1;
      end
      MCBA_DS_NOP: file_wr = 1'b0;
      MCBA_DS_RAMA, MCBA_DS_RAMF: ram_in = f;
      MCBA_DS_RAMQD: begin
        ram_in = {ram_top_fill, f[7:1]};
        q_in = {q_top_fill, q_reg[7:1]};
        q_ld = 1'b1;
      end
      MCBA_DS_RAMD: ram_in = {ram_top_fill, f[7:1]};
      MCBA_DS_RAMQU: begin
        ram_in = {f[6:0], ram_bot_fill};
        q_in = {q_reg[6:0], q_bot_fill};
        q_ld = 1'b1;
      end
      MCBA_DS_RAMU: ram_in = {f[6:0], ram_bot_fill};
    endcase
  end

  // file write lands on the clock that closes the late strobe
  always_ff @(posedge CLK_SYS_IN) begin
    if (cycle_end && file_wr) begin
      work_file[b_addr] <= ram_in;
    end
  end

  // Q and result holding register update as the strobe releases
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q_reg <= 8'h00;
      f_hold_reg <= 8'h00;
    end else if (cycle_end) begin
      f_hold_reg <= f;
      if (q_ld) begin
        q_reg <= q_in;
      end
    end
  end

  // condition codes only when the microword asks, else kept
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cc_reg <= '0;
    end else if (cycle_end && microword_register[MCBA_CC_BIT]) begin
      cc_reg <= flags_now;
    end
  end

  // microword: tracks the written value while idle, steps at cycle end
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      microword_register <= MCBA_MW_RST;
    end else if (!busy || cycle_end) begin
      microword_register <= mw_next_reg;
    end
  end

  // bus driver: off for store or register reads and in the first quarter
  assign bus_drive = busy && !early_phase_window
    && microword_register[MCBA_LS_BIT]
    && !(microword_register[MCBA_DER_RD_BIT] && microword_register[MCBA_DER_BIT]);

  // pin outputs registered; one clock lag versus the phase is accepted
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BUS_OUT <= 8'h00;
      BUS_OE_N_OUT <= 1'b1;
      ACCUM_SHIFT_TOP_LINE_OUT <= 1'b0;
      ACCUM_SHIFT_TOP_LINE_OE_N_OUT <= 1'b1;
      ACCUM_SHIFT_BOTTOM_LINE_OUT <= 1'b0;
      ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT <= 1'b1;
      FLAGS_OUT <= '0;
      EARLY_PHASE_WINDOW_OUT <= 1'b1;
      LATE_PHASE_STROBE_OUT <= 1'b0;
    end else begin
      BUS_OUT <= (dst == MCBA_DS_RAMA) ? a_lat_reg : f;
      BUS_OE_N_OUT <= !bus_drive;
      // q end lines: bottom is shifted out going down, top going up
      ACCUM_SHIFT_BOTTOM_LINE_OUT <= q_reg[0];
      ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT <= !(dst == MCBA_DS_RAMQD);
      ACCUM_SHIFT_TOP_LINE_OUT <= q_reg[7];
      ACCUM_SHIFT_TOP_LINE_OE_N_OUT <= !(dst == MCBA_DS_RAMQU);
      FLAGS_OUT <= cc_reg;
      EARLY_PHASE_WINDOW_OUT <= early_phase_window;
      LATE_PHASE_STROBE_OUT <= late_phase_strobe;
    end
  end

  // axi write address and data captured independently
  assign do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID_OUT;
  assign wr_hit = (aw_addr_reg == MCBA_CTRL_OFS) || (aw_addr_reg == MCBA_MWLO_OFS)
    || (aw_addr_reg == MCBA_MWHI_OFS);
  assign step_set = do_write && (aw_addr_reg == MCBA_CTRL_OFS) && w_strb_reg[0]
    && w_data_reg[MCBA_CTRL_STEP];

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      S_AXI_AWREADY_OUT <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held_reg && !S_AXI_AWREADY_OUT;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      S_AXI_WREADY_OUT <= 1'b0;
    end else begin
      S_AXI_WREADY_OUT <= !w_held_reg && !S_AXI_WREADY_OUT;
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA_IN;
        w_strb_reg <= S_AXI_WSTRB_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= MCBA_RESP_OK;
    end else if (do_write) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT <= wr_hit ? MCBA_RESP_OK : MCBA_RESP_ERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // software registers; byte lanes honoured, step is a write pulse
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      {cin_reg, run_reg} <= MCBA_CTRL_RST;
      mw_next_reg <= MCBA_MW_RST;
    end else if (do_write) begin
      if (aw_addr_reg == MCBA_CTRL_OFS && w_strb_reg[0]) begin
        run_reg <= w_data_reg[MCBA_CTRL_RUN];
        cin_reg <= w_data_reg[MCBA_CTRL_CIN];
      end
      for (int i = 0; i < 4; i++) begin
        if (aw_addr_reg == MCBA_MWLO_OFS && w_strb_reg[i]) begin
          mw_next_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
        end
      end
      if (aw_addr_reg == MCBA_MWHI_OFS && w_strb_reg[0]) begin
        mw_next_reg[MCBA_DST_HI:MCBA_DST_LO] <= w_data_reg[2:0];
      end
    end
  end

  // pending step: cleared in the first busy clock with run off; a new request in that clock wins over the clear
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      step_reg <= 1'b0;
    end else if (step_set) begin
      step_reg <= 1'b1;
    end else if (busy && !run_reg && step_reg) begin
      step_reg <= 1'b0;
    end
  end

  // read channel: one read at a time, answered two clocks after arvalid
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= MCBA_RESP_OK;
    end else begin
      S_AXI_ARREADY_OUT <= S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT;
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT <= MCBA_RESP_OK;
        unique case (S_AXI_ARADDR_IN)
          MCBA_CTRL_OFS: S_AXI_RDATA_OUT <= {29'h0, step_reg, cin_reg, run_reg};
          MCBA_MWLO_OFS: S_AXI_RDATA_OUT <= mw_next_reg[31:0];
          MCBA_MWHI_OFS: S_AXI_RDATA_OUT <= {29'h0, mw_next_reg[MCBA_DST_HI:MCBA_DST_LO]};
          MCBA_STAT_OFS: S_AXI_RDATA_OUT <= {11'h0, busy, cc_reg, q_reg, f_hold_reg};
          MCBA_AB_OFS: S_AXI_RDATA_OUT <= {16'h0, b_lat_reg, a_lat_reg};
          default: begin
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= MCBA_RESP_ERR;
          end
        endcase
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

endmodule : mcba_top

// ==== mcba_chk.sv ====
module mcba_chk
  import mcba_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // register bus handshakes
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // datapath side
  input wire logic BUS_OE_N_OUT,
  input wire logic ACCUM_SHIFT_TOP_LINE_OE_N_OUT,
  input wire logic ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT,
  input wire mcba_flags_t FLAGS_OUT,
  input wire logic EARLY_PHASE_WINDOW_OUT,
  input wire logic LATE_PHASE_STROBE_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // bus stays released while the previous driver lets go
  property p_oe_early; EARLY_PHASE_WINDOW_OUT |-> BUS_OE_N_OUT; endproperty
  a_oe_early: assert property (p_oe_early) else $error("bus driven in early phase");
  // three clocks a phase, four phases a microcycle
  property p_late_len; $rose(LATE_PHASE_STROBE_OUT) |-> LATE_PHASE_STROBE_OUT[*3] ##1 !LATE_PHASE_STROBE_OUT; endproperty
  a_late_len: assert property (p_late_len) else $error("late strobe length wrong");
  property p_phase_gap; $fell(EARLY_PHASE_WINDOW_OUT) |-> !LATE_PHASE_STROBE_OUT[*6] ##1 LATE_PHASE_STROBE_OUT; endproperty
  a_phase_gap: assert property (p_phase_gap) else $error("late strobe misplaced");
  property p_excl; !(EARLY_PHASE_WINDOW_OUT && LATE_PHASE_STROBE_OUT); endproperty
  a_excl: assert property (p_excl) else $error("early and late overlap");
  // only one q end line can be an output at a time
  property p_qends; !ACCUM_SHIFT_TOP_LINE_OE_N_OUT |-> ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT; endproperty
  a_qends: assert property (p_qends) else $error("both q end lines driven");
  // flags move only around the end of the late phase
  property p_flags; $changed(FLAGS_OUT) |-> LATE_PHASE_STROBE_OUT || $past(LATE_PHASE_STROBE_OUT)
    || $past(LATE_PHASE_STROBE_OUT, 2); endproperty
  a_flags: assert property (p_flags) else $error("flags changed mid cycle");
  property p_bhold; S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT); endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_busy; S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT; endproperty
  a_busy: assert property (p_busy) else $error("write taken while response pending");
  c_late: cover property ($rose(LATE_PHASE_STROBE_OUT));
  c_drive: cover property (!BUS_OE_N_OUT);
  c_qtop: cover property (!ACCUM_SHIFT_TOP_LINE_OE_N_OUT);
endmodule : mcba_chk

bind mcba_top mcba_chk i_chk (.*);

// ==== mcba_far.sv ====
module mcba_far
  import mcba_pkg::*;
(
  input wire logic clk_in,
  input wire logic dp_oe_n_in,
  input wire logic [MCBA_DW-1:0] dp_data_in,
  input wire logic ls_en_in,
  input wire logic [MCBA_DW-1:0] ls_data_in,
  output logic [MCBA_DW-1:0] bus_out
);
  logic [MCBA_DW-1:0] last_reg = 8'h00; // last level seen on the bus
  always_ff @(posedge clk_in) begin
    last_reg <= bus_out;
  end
  // nobody driving: show a moving pattern, never a stale byte
  always_comb begin
    if (!dp_oe_n_in) begin
      bus_out = dp_data_in;
    end else if (ls_en_in) begin
      bus_out = ls_data_in;
    end else begin
      bus_out = ~last_reg;
    end
  end
endmodule : mcba_far

// ==== testbench.sv ====
module testbench import mcba_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, aw_v, w_v, b_r, ar_v, r_r, ls_en, drv, qt, qb, qv;
  logic aw_r, w_r, b_v, ar_r, r_v, oe_n, qt_oe_n, qb_oe_n, early, late;
  logic [4:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, st;
  logic [1:0] b_resp, r_resp, rs;
  logic [7:0] bus_i, bus_o, ls_d, bv;
  mcba_flags_t flg;
  int num_errors = 0;
  int check_count = 0;
  // write strobes tied on: every register is one full word
  mcba_top i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(aw_a),
    .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(aw_r), .S_AXI_WDATA_IN(w_d),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_r),
    .S_AXI_BRESP_OUT(b_resp), .S_AXI_BVALID_OUT(b_v), .S_AXI_BREADY_IN(b_r),
    .S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_r),
    .S_AXI_RDATA_OUT(r_d), .S_AXI_RRESP_OUT(r_resp), .S_AXI_RVALID_OUT(r_v),
    .S_AXI_RREADY_IN(r_r), .BUS_IN(bus_i), .BUS_OUT(bus_o), .BUS_OE_N_OUT(oe_n),
    .ACCUM_SHIFT_TOP_LINE_OUT(qt), .ACCUM_SHIFT_TOP_LINE_OE_N_OUT(qt_oe_n),
    .ACCUM_SHIFT_BOTTOM_LINE_OUT(qb), .ACCUM_SHIFT_BOTTOM_LINE_OE_N_OUT(qb_oe_n),
    .FLAGS_OUT(flg), .EARLY_PHASE_WINDOW_OUT(early), .LATE_PHASE_STROBE_OUT(late));
  mcba_far i_far (.clk_in(clk), .dp_oe_n_in(oe_n), .dp_data_in(bus_o), .ls_en_in(ls_en),
    .ls_data_in(ls_d), .bus_out(bus_i));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // a wait that ran out ends the run
  task automatic hang(input int n);
    if (n >= 50) begin
      num_errors++;
      results();
    end
  endtask : hang
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    {aw_v, w_v, b_r} <= 3'h7;
    do begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      n++;
    end while (!b_v && n < 50);
    b_r <= 1'b0;
    chk(b_resp, MCBA_RESP_OK);
    hang(n);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    int n = 0;
    @(posedge clk);
    ar_a <= a;
    {ar_v, r_r} <= 2'h3;
    do begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
      n++;
    end while (!r_v && n < 50);
    st = r_d;
    rs = r_resp;
    r_r <= 1'b0;
    hang(n);
  endtask : rd
  // one stepped microcycle; bus and q end line activity recorded, then status read
  task automatic uc(input logic [2:0] d, f, s, input logic [9:0] m, input logic [3:0] b, a,
    input logic [7:0] lo, input logic cin);
    wr(MCBA_MWLO_OFS, {f, s, m, b, a, lo});
    wr(MCBA_MWHI_OFS, {29'h0, d});
    wr(MCBA_CTRL_OFS, {29'h0, 1'b1, cin, 1'b0});
    drv = 1'b0;
    qv = 1'bx;
    repeat (16) begin
      @(posedge clk);
      if (!oe_n) begin
        drv = 1'b1;
        bv = bus_o;
      end
      if (!qt_oe_n) qv = qt;
      if (!qb_oe_n) qv = qb;
    end
    rd(MCBA_STAT_OFS);
    chk(st[20], 1'b0);
  endtask : uc
  // bus byte ORed with zero, stored by destination code d
  task automatic load(input logic [2:0] d, input logic [3:0] r, input logic [7:0] v);
    ls_d <= v;
    uc(d, 3'h3, 3'h7, 10'h0, r, 4'h0, 8'h00, 1'b0);
    chk(drv, 1'b0);
    chk(st[7:0], v);
  endtask : load
  initial begin
    rst = 1'b1;
    {aw_v, w_v, b_r, ar_v, r_r} = '0;
    ls_en = 1'b1;
    {aw_a, ar_a, w_d, ls_d} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(MCBA_CTRL_OFS);
    chk(st, 32'h0);
    rd(5'h1C);
    chk(rs, MCBA_RESP_ERR);
    load(3'h3, 4'h1, 8'h7F);
    load(3'h3, 4'h2, 8'h01);
    // positive plus positive turning negative
    uc(3'h1, 3'h0, 3'h1, 10'h0, 4'h2, 4'h1, 8'h88, 1'b0);
    chk(st[7:0], 8'h80);
    chk(st[19:16], 4'h6);
    chk(bv, 8'h80);
    uc(3'h1, 3'h2, 3'h1, 10'h0, 4'h1, 4'h2, 8'h80, 1'b0);
    chk(st[7:0], 8'h82);
    chk(st[19:16], 4'h6);
    // same register on both ports gives a zero across both nibbles
    uc(3'h1, 3'h6, 3'h1, 10'h0, 4'h1, 4'h1, 8'h88, 1'b0);
    chk(st[19:16], 4'h8);
    uc(3'h1, 3'h0, 3'h1, 10'h0, 4'h2, 4'h2, 8'h80, 1'b1);
    chk(st[7:0], 8'h03);
    load(3'h0, 4'h0, 8'h81);
    chk(st[15:8], 8'h81);
    // double rotate up, then single shift down
    uc(3'h6, 3'h3, 3'h3, 10'h0, 4'h1, 4'h1, 8'h03, 1'b0);
    chk(st[15:8], 8'h02);
    chk(qv, 1'b0);
    rd(MCBA_AB_OFS);
    chk(st[15:0], 16'hFFFF);
    uc(3'h4, 3'h3, 3'h3, 10'h0, 4'h1, 4'h1, 8'h00, 1'b0);
    chk(st[15:8], 8'h01);
    chk(qv, 1'b1);
    rd(MCBA_AB_OFS);
    chk(st[15:0], 16'h7F7F);
    @(posedge clk);
    ls_en <= 1'b0;
    uc(3'h2, 3'h4, 3'h1, 10'h0, 4'h2, 4'h1, 8'h80, 1'b0);
    chk(st[7:0], 8'h01);
    chk(bv, 8'h7F);
    // register read cycle keeps the driver off
    uc(3'h1, 3'h3, 3'h1, 10'h080, 4'h2, 4'h1, 8'hA0, 1'b0);
    chk(drv, 1'b0);
    results();
  end
endmodule : testbench
